//--- test/mks_matrix_model.sv
// electrode matrix with ramp comparators on three receive lines
// assumes one-hot ramp enables; line 2 never crosses, so it times out
`timescale 1ns/1ps
`default_nettype none
module mks_matrix_model #(
    parameter int D0 = 30,
    parameter int D1 = 7
) (
    input  wire logic [2:0] ramp_enable_i,
    input  wire logic       sys_clk_i,
    output logic      [2:0] zero_cross_o
);
    int   cnt [3];
    logic tog = 1'b0;
    // each path ramps its own capacitor only while enabled
    always @(posedge sys_clk_i) begin
        tog <= !tog;
        for (int r = 0; r < 3; r++) begin
            cnt[r] <= ramp_enable_i[r] ? cnt[r] + 1 : 0;
        end
    end
    // comparators 0 and 1 trip a fixed time after ramp start, comparator 2 never; noise otherwise
    always_comb begin
        zero_cross_o[0] = ramp_enable_i[0] ? cnt[0] >= D0 : tog;
        zero_cross_o[1] = ramp_enable_i[1] ? cnt[1] >= D1 : !tog;
        zero_cross_o[2] = ramp_enable_i[2] ? 1'b0 : tog;
    end
endmodule
`default_nettype wire

//--- test/mks_seq_properties.sv
// port checks for the scan sequencer
// assumes the bind below reaches every mks_seq instance
`timescale 1ns/1ps
`default_nettype none
module mks_seq_chk #(
    parameter int RAMP_LIMIT = 65535
) (
    input wire logic                 sys_clk_i,
    input wire logic                 sys_rst_i,
    input wire logic [191:0]         burst_pulse_count_i,
    input wire logic [95:0]          detect_integrator_limit_i,
    input wire logic [7:0]           drive_line_o,
    input wire logic [2:0]           recv_clamp_o,
    input wire logic [2:0]           ramp_enable_o,
    input wire logic                 result_valid_o,
    input wire mks_pkg::mks_result_t result_o,
    input wire logic [4:0]           active_key_o
);
    logic [7:0] drv_r, drv_nxt, clp_r, clp_nxt, pls_r, pls_nxt;
    logic       hi_r, hi_nxt;
    // run lengths of drive and clamp, and pulses since the last ramp
    always_comb begin
        hi_nxt  = |drive_line_o;
        drv_nxt = hi_nxt ? drv_r + 8'h01 : 8'h00;
        clp_nxt = |recv_clamp_o ? clp_r + 8'h01 : 8'h00;
        pls_nxt = |ramp_enable_o ? 8'h00 : pls_r + 8'(hi_nxt && !hi_r);
    end
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            {hi_r, drv_r, clp_r, pls_r} <= '0;
        end else begin
            {hi_r, drv_r, clp_r, pls_r} <= {hi_nxt, drv_nxt, clp_nxt, pls_nxt};
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence pulse_end_s; $fell(|drive_line_o); endsequence
    sequence ramp_start_s; $rose(|ramp_enable_o); endsequence
    drive_key_a: assert property (drive_line_o != 0 |-> drive_line_o == 8'h01 << active_key_o[2:0])
        else $error("drive line does not match key");
    clamp_key_a: assert property (recv_clamp_o != 0 |-> recv_clamp_o == 3'h1 << active_key_o[4:3])
        else $error("clamp line does not match key");
    ramp_path_a: assert property (ramp_enable_o != 0 |-> ramp_enable_o == 3'h1 << active_key_o[4:3]
        && drive_line_o == 0 && recv_clamp_o == 0) else $error("ramp path wrong");
    pulse_clamp_a: assert property (pulse_end_s |-> recv_clamp_o != 0 && drv_r == mks_pkg::DWELL_CYC)
        else $error("no clamp after pulse");
    burst_len_a: assert property (ramp_start_s |-> clp_r >= mks_pkg::SETTLE_CYC
        && pls_r == burst_pulse_count_i[active_key_o*8 +: 8]) else $error("burst length wrong");
    key_enabled_a: assert property (drive_line_o != 0 |->
        detect_integrator_limit_i[active_key_o*4 +: 4] != 0) else $error("disabled key driven");
    result_ramp_a: assert property (result_valid_o |-> $past(ramp_enable_o != 0)
        || $past(ramp_enable_o != 0, 2)) else $error("result without ramp");
    timeout_count_a: assert property (result_valid_o && result_o.timeout |->
        result_o.count == RAMP_LIMIT) else $error("timeout count wrong");
endmodule
bind mks_seq mks_seq_chk #(.RAMP_LIMIT(RAMP_LIMIT)) u_chk (.sys_clk_i, .sys_rst_i, .burst_pulse_count_i,
    .detect_integrator_limit_i, .drive_line_o, .recv_clamp_o, .ramp_enable_o, .result_valid_o, .result_o,
    .active_key_o);
`default_nettype wire

//--- test/mks_seq_tb_top.sv
// bench for mks_seq: rows of key masks and burst lengths
// assumes the matrix model drives the comparators
`timescale 1ns/1ps
`default_nettype none
module mks_seq_tb_top;
    localparam int RL = 100;
    typedef struct {logic [23:0] en; logic [7:0] bpc; logic cal;} mks_row_t;
    mks_row_t rows [4] = '{'{24'hFF_FFFF, 8'h02, 1'b0}, '{24'h80_0181, 8'h00, 1'b1},
                          '{24'h5A_A5FE, 8'h01, 1'b0}, '{24'h00_0000, 8'h01, 1'b0}};
    logic                 sys_clk_i = 1'b0;
    logic                 sys_rst_i = 1'b1;
    logic                 cal = 1'b0;
    logic [191:0]         bpc_v = '0;
    logic [95:0]          dil_v = '0;
    logic [7:0]           drv;
    logic [2:0]           zc, clamp, ramp;
    logic [4:0]           akey;
    logic                 vld, cbusy;
    mks_pkg::mks_result_t res;
    logic [383:0]         raw;
    int                   err_count = 0, n_compared = 0, cyc = 0, k, c;
    mks_seq #(.RAMP_LIMIT(RL)) uut (.sys_clk_i, .sys_rst_i, .burst_pulse_count_i(bpc_v),
        .detect_integrator_limit_i(dil_v), .calib_req_i(cal), .zero_cross_i(zc), .drive_line_o(drv),
        .recv_clamp_o(clamp), .ramp_enable_o(ramp), .result_valid_o(vld), .result_o(res),
        .active_key_o(akey), .calib_busy_o(cbusy), .raw_signal_o(raw));
    mks_matrix_model u_model (.ramp_enable_i(ramp), .sys_clk_i, .zero_cross_o(zc));
    initial forever #12.5 sys_clk_i = !sys_clk_i;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        if (err_count == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count++;
            test_done;
        end
    end
    task automatic wait_res;
        @(posedge sys_clk_i);
        #1;
        for (int i = 0; i < 3000 && vld !== 1'b1; i++) begin
            @(posedge sys_clk_i);
            #1;
        end
        chk(vld, 1'b1);
    endtask
    initial begin
        foreach (rows[i]) begin
            @(posedge sys_clk_i);
            sys_rst_i <= 1'b1;
            cal <= rows[i].cal;
            for (int j = 0; j < 24; j++) begin
                bpc_v[j*8 +: 8] <= rows[i].bpc + 8'(j % 2);
                dil_v[j*4 +: 4] <= rows[i].en[j] ? 4'h3 : 4'h0;
            end
            repeat (8) @(posedge sys_clk_i);
            #1 chk({drv, clamp, ramp, vld, akey}, 0);
            @(posedge sys_clk_i);
            sys_rst_i <= 1'b0;
            c = $countones(rows[i].en);
            k = 0;
            while (c > 0 && !rows[i].en[k]) k++;
            for (int n = 0; n < 2 * c; n++) begin
                wait_res();
                chk(res.key, k);
                chk({res.timeout, res.count}, k < 8 ? 30 : k < 16 ? 7 : 32'h0001_0000 + RL);
                chk(raw[k*16 +: 16], k < 8 ? 30 : k < 16 ? 7 : RL);
                chk(cbusy, (n >= c - 1) && rows[i].cal);
                if (n >= c) chk(res.calib, rows[i].cal);
                do k = (k + 1) % 24; while (!rows[i].en[k]);
                chk(akey, k);
            end
            if (c == 0) begin
                repeat (300) @(posedge sys_clk_i);
                #1 chk({drv, clamp, ramp, vld}, 0);
            end
        end
        test_done;
    end
endmodule
`default_nettype wire

//--- verilog/mks_pkg.sv
// constants and carrier types for the matrix key scan sequencer
// assumes a single 40 MHz system clock and external analog front end
//
// Functional notes
// - keys acquired one at a time, 0..23, starting at drive 0 receive 0
// - order: all drive lines 0..7 on receive 0, then receive 1, then 2
// - key number is eight times receive index plus drive index
// - each key sampled by a burst whose pulse count is set per key
// - a burst finishes completely before the next key starts
// - after each burst the signal is converted and passed on
// - keys with zero detect integrator limit are skipped entirely
// - calibration passes cover only enabled keys
// - receive line clamped to ground on each drive pulse falling edge
// - after last pulse clamp receive line, then let ramp rise via resistor
// - time from ramp start to zero crossing is the key's result
// - single-slope conversion, one path per receive line
// - raw signal values made available alongside key status
package mks_pkg;

    localparam int NUM_DRIVE = 8;
    localparam int NUM_RECV  = 3;
    localparam int NUM_KEYS  = NUM_DRIVE * NUM_RECV;
    localparam int KEY_W     = 5;
    localparam int BURST_W   = 8;
    localparam int DIL_W     = 4;
    localparam int RES_W     = 16;

    // drive pulse high and low phases and settle time, in ns, and derived cycle counts
    localparam int DWELL_NS      = 500;
    localparam int CLAMP_NS      = 500;
    localparam int SETTLE_NS     = 1000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int DWELL_CYC  = (DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLAMP_CYC  = (CLAMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PH_W       = 8;

    localparam logic [RES_W-1:0] RES_MAX = 16'hFFFF;

    typedef enum logic [2:0] {
        MKS_IDLE   = 3'b000,
        MKS_PULSE  = 3'b001,
        MKS_CLAMP  = 3'b010,
        MKS_SETTLE = 3'b011,
        MKS_RAMP   = 3'b100
    } mks_state_t;

    typedef struct packed {
        logic [KEY_W-1:0] key;
        logic [RES_W-1:0] count;
        logic             timeout;
        logic             calib;
    } mks_result_t;

endpackage

//--- verilog/mks_seq.sv
// scan and acquisition sequencer for a 24-key drive/receive matrix
// assumes per-key settings are held elsewhere and presented as flat vectors;
// zero-crossing comparators per receive line are synchronous inputs
`timescale 1ns/1ps
`default_nettype none
module mks_seq #(
    parameter int RAMP_LIMIT = 65535
) (
    input  wire logic                                          sys_clk_i,
    input  wire logic                                          sys_rst_i,
    input  wire logic [mks_pkg::NUM_KEYS*mks_pkg::BURST_W-1:0] burst_pulse_count_i,
    input  wire logic [mks_pkg::NUM_KEYS*mks_pkg::DIL_W-1:0]   detect_integrator_limit_i,
    input  wire logic                                          calib_req_i,
    input  wire logic [mks_pkg::NUM_RECV-1:0]                  zero_cross_i,
    output logic      [mks_pkg::NUM_DRIVE-1:0]                 drive_line_o,
    output logic      [mks_pkg::NUM_RECV-1:0]                  recv_clamp_o,
    output logic      [mks_pkg::NUM_RECV-1:0]                  ramp_enable_o,
    output logic                                               result_valid_o,
    output mks_pkg::mks_result_t                               result_o,
    output logic      [mks_pkg::KEY_W-1:0]                     active_key_o,
    output logic                                               calib_busy_o,
    output logic      [mks_pkg::NUM_KEYS*mks_pkg::RES_W-1:0]   raw_signal_o
);

    localparam int NK = mks_pkg::NUM_KEYS;
    localparam int RW = mks_pkg::RES_W;

    logic [NK-1:0] key_en;
    logic [mks_pkg::BURST_W-1:0] burst_len [NK];

    genvar g;
    generate
        for (g = 0; g < NK; g++) begin : g_key
            assign key_en[g] = (detect_integrator_limit_i[g*mks_pkg::DIL_W +: mks_pkg::DIL_W] != '0);
            assign burst_len[g] = burst_pulse_count_i[g*mks_pkg::BURST_W +: mks_pkg::BURST_W];
        end
    endgenerate

    mks_pkg::mks_state_t        state_r, state_nxt;
    logic [mks_pkg::KEY_W-1:0]  key_r, key_nxt;
    logic [mks_pkg::BURST_W-1:0] pulse_r, pulse_nxt;
    logic [mks_pkg::PH_W-1:0]   ph_r, ph_nxt;
    logic [RW-1:0]              ramp_r, ramp_nxt;
    logic                       calib_r, calib_nxt;
    logic                       valid_r, valid_nxt;
    mks_pkg::mks_result_t       res_r, res_nxt;
    logic [RW-1:0]              raw_r [NK];
    logic [mks_pkg::KEY_W-1:0]  next_key;
    logic                       next_wraps;
    logic                       any_en;
    logic [1:0]                 recv_idx;
    logic [2:0]                 drv_idx;

    // key = 8*receive + drive
    assign recv_idx = key_r[4:3];
    assign drv_idx  = key_r[2:0];

    // next enabled key after key_r in ascending order, wrapping past 23
    always_comb begin
        next_key   = '0;
        next_wraps = 1'b1;
        any_en     = |key_en;
        for (int i = NK - 1; i >= 0; i--) begin
            if (key_en[i] && (i > int'(key_r))) begin
                next_key   = mks_pkg::KEY_W'(i);
                next_wraps = 1'b0;
            end
        end
        if (next_wraps) begin
            for (int i = NK - 1; i >= 0; i--) begin
                if (key_en[i]) begin
                    next_key = mks_pkg::KEY_W'(i);
                end
            end
        end
    end

    always_comb begin
        state_nxt   = state_r;
        key_nxt     = key_r;
        pulse_nxt   = pulse_r;
        ph_nxt      = ph_r;
        ramp_nxt    = ramp_r;
        calib_nxt   = calib_r;
        valid_nxt   = 1'b0;
        res_nxt     = res_r;
        unique case (state_r)
            mks_pkg::MKS_IDLE: begin
                if (any_en) begin
                    // start on key 0 when enabled, else on the next enabled key after key_r (the lowest one after reset)
                    key_nxt   = key_en[0] ? '0 : next_key;
                    pulse_nxt = '0;
                    ph_nxt    = '0;
                    state_nxt = mks_pkg::MKS_PULSE;
                end
            end
            mks_pkg::MKS_PULSE: begin
                if (burst_len[key_r] == '0) begin
                    ph_nxt    = '0;
                    state_nxt = mks_pkg::MKS_SETTLE;
                end else if (ph_r == mks_pkg::PH_W'(mks_pkg::DWELL_CYC - 1)) begin
                    ph_nxt    = '0;
                    state_nxt = mks_pkg::MKS_CLAMP;  // falling edge of drive
                end else begin
                    ph_nxt = ph_r + 1'b1;
                end
            end
            mks_pkg::MKS_CLAMP: begin
                if (ph_r == mks_pkg::PH_W'(mks_pkg::CLAMP_CYC - 1)) begin
                    ph_nxt = '0;
                    if (pulse_r + 1'b1 >= burst_len[key_r]) begin
                        state_nxt = mks_pkg::MKS_SETTLE;
                    end else begin
                        pulse_nxt = pulse_r + 1'b1;
                        state_nxt = mks_pkg::MKS_PULSE;
                    end
                end else begin
                    ph_nxt = ph_r + 1'b1;
                end
            end
            mks_pkg::MKS_SETTLE: begin
                if (ph_r == mks_pkg::PH_W'(mks_pkg::SETTLE_CYC - 1)) begin
                    ramp_nxt  = '0;
                    state_nxt = mks_pkg::MKS_RAMP;
                end else begin
                    ph_nxt = ph_r + 1'b1;
                end
            end
            mks_pkg::MKS_RAMP: begin
                if (zero_cross_i[recv_idx] || ramp_r == RW'(RAMP_LIMIT)) begin
                    valid_nxt     = 1'b1;
                    res_nxt.key   = key_r;
                    res_nxt.count = ramp_r;
                    res_nxt.timeout = ~zero_cross_i[recv_idx];
                    res_nxt.calib = calib_r;
                    pulse_nxt = '0;
                    ph_nxt    = '0;
                    // the calibration marker changes only at a scan wrap
                    if (next_wraps) begin
                        calib_nxt = calib_req_i;
                    end
                    if (any_en) begin
                        key_nxt   = next_key;
                        state_nxt = mks_pkg::MKS_PULSE;
                    end else begin
                        state_nxt = mks_pkg::MKS_IDLE;
                    end
                end else begin
                    ramp_nxt = ramp_r + 1'b1;
                end
            end
            default: state_nxt = mks_pkg::MKS_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state_r   <= mks_pkg::MKS_IDLE;
            key_r     <= '0;
            pulse_r   <= '0;
            ph_r      <= '0;
            ramp_r    <= '0;
            calib_r   <= 1'b0;
            valid_r   <= 1'b0;
            res_r     <= '0;
        end else begin
            state_r   <= state_nxt;
            key_r     <= key_nxt;
            pulse_r   <= pulse_nxt;
            ph_r      <= ph_nxt;
            ramp_r    <= ramp_nxt;
            calib_r   <= calib_nxt;
            valid_r   <= valid_nxt;
            res_r     <= res_nxt;
        end
    end

    // per-key raw signal store, readable at any time
    generate
        for (g = 0; g < NK; g++) begin : g_raw
            logic [RW-1:0] raw_nxt;
            always_comb begin
                raw_nxt = raw_r[g];
                if (valid_nxt && key_r == mks_pkg::KEY_W'(g)) begin
                    raw_nxt = res_nxt.count;
                end
            end
            always_ff @(posedge sys_clk_i) begin
                if (sys_rst_i) begin
                    raw_r[g] <= '0;
                end else begin
                    raw_r[g] <= raw_nxt;
                end
            end
            assign raw_signal_o[g*RW +: RW] = raw_r[g];
        end
    endgenerate

    // pin drive: one drive line high during pulse phase, one path per receive line
    always_comb begin
        drive_line_o  = '0;
        recv_clamp_o  = '0;
        ramp_enable_o = '0;
        if (state_r == mks_pkg::MKS_PULSE && burst_len[key_r] != '0) begin
            drive_line_o[drv_idx] = 1'b1;
        end
        if (state_r == mks_pkg::MKS_CLAMP || state_r == mks_pkg::MKS_SETTLE) begin
            recv_clamp_o[recv_idx] = 1'b1;
        end
        if (state_r == mks_pkg::MKS_RAMP) begin
            ramp_enable_o[recv_idx] = 1'b1;
        end
    end

    assign result_valid_o = valid_r;
    assign result_o       = res_r;
    assign active_key_o   = key_r;
    assign calib_busy_o   = calib_r;

endmodule
`default_nettype wire
